// ### verilog/dip_ctrl.sv
// interrupt controller with power-down, idle and reset sequencing
`timescale 1ns/1ps
// Functional notes
// - request ANDed with mask, highest unmasked priority picked.
// - power-down interrupt ignores the mask.
// - mask write blocks all interrupts for one processor cycle.
// - control register sets nesting and edge/level for ext zero, one, two.
// - edge input latched and forceable/clearable; level inputs always level.
// - force/clear register write-only, sets or clears pending requests.
// - status pushed/popped on shared twelve-entry stack.
// - global enable/disable gates all servicing including power-down.
// - global enable set after reset.
// - wake with oscillator running takes 400 input clocks.
// - wake with oscillator off takes 4096 input clocks.
// - power-down by pin or software bit, edge and nonmaskable.
// - context bit chooses resume or cleared restart after power-down.
// - reset ends power-down; acknowledge output shows power-down.
// - idle stalls until unmasked interrupt, then continues.
// - slowed idle divides cycle by 16, 32, 64 or 128.
// - slowed idle may linger up to divisor cycles after interrupt.
// - processor cycles derived from input clock, never halted.
// - cycle clock output, switchable by disable bit.
// - reset empties stack, masks all, clears mode status, then boots.
module dip_ctrl
  import dip_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  input  wire logic              power_down_pin_n_i,
  input  wire logic              edge_interrupt_in_n_i,
  input  wire logic              level_interrupt_in_a_n_i,
  input  wire logic              level_interrupt_in_b_n_i,
  input  wire logic              ext_interrupt_zero_n_i,
  input  wire logic              ext_interrupt_one_n_i,
  input  wire logic              ext_interrupt_two_n_i,
  input  wire logic [5:0]        periph_irq_i,
  input  wire dip_core_s         core_i,
  input  wire logic              bus_req_i,
  input  wire logic              boot_cfg_i,
  input  wire logic              boot_done_i,
  output logic                   irq_o,
  output logic [3:0]             irq_src_o,
  output logic [13:0]            vector_addr_o,
  output logic [15:0]            stack_top_o,
  output logic                   stall_o,
  output logic                   cyc_en_o,
  output logic                   cycle_clock_output_o,
  output logic                   power_down_ack_o,
  output logic                   ctx_clear_o,
  output logic                   start_o,
  output logic [15:0]            start_pc_o,
  output logic [6:0]             mode_status_reg_o
);
  initial begin
    if (ADDR_W < 8) $error("ADDR_W below 8 cannot decode the map");
  end

  localparam logic [12:0] WAKE_FAST_CYC = 13'(WAKE_FAST - 1);
  localparam logic [12:0] WAKE_CRYSTAL_PIN_CYC = 13'(WAKE_CRYSTAL_PIN - 1);

  typedef struct packed {
    dip_state_e          st;
    logic [SRC_N-1:0]    pend;
    logic [SRC_N-1:0]    isr;
    logic [9:0]          mask;
    logic [3:0]          interrupt_control_reg;
    logic                gie;
    logic                blk;
    logic                irq;
    logic [3:0]          vec;
    logic [13:0]         vaddr;
    logic [4:0]          prev;
    logic                osc_off;
    logic                ctx_clr;
    logic                clk_dis;
    logic [2:0]          idiv;
    logic [6:0]          mode_status_reg;
    logic [6:0]          div;
    logic [12:0]         cnt;
    logic                cyc;
    logic                clko;
    logic                ctx;
    logic                start;
    logic                pd_ack;
    logic [3:0]          sp;
    logic [11:0][15:0]   stk;
    logic [15:0]         top;
    logic                awh;
    logic                wh;
    logic                awr;
    logic                wr;
    logic [7:0]          awa;
    logic [31:0]         wd;
    logic [3:0]          ws;
    logic                bv;
    logic [1:0]          br;
    logic                arr;
    logic                rv;
    logic [31:0]         rd;
    logic [1:0]          rr;
  } dip_st_s;

  dip_st_s s;
  dip_st_s n;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]       pins;
    logic [4:0]       fall;
    logic [SRC_N-1:0] set;
    logic [SRC_N-1:0] clr;
    logic [SRC_N-1:0] lvl;
    logic [SRC_N-1:0] eff;
    logic [SRC_N-1:0] cand;
    logic [31:0]      wm;
    logic [31:0]      rdv;
    logic [6:0]       lim;
    logic [3:0]       top_i;
    logic [3:0]       pick;
    logic             found;
    logic             wen;
    logic             go_pd;
    logic             go_idle;
    logic             allow;
    logic             take;
    logic             push;
    logic             pop;
    n = s;
    pins = {power_down_pin_n_i, edge_interrupt_in_n_i, ext_interrupt_two_n_i,
            ext_interrupt_one_n_i, ext_interrupt_zero_n_i};
    fall = s.prev & ~pins;
    n.prev = pins;
    set = '0;
    clr = '0;
    lvl = '0;
    rdv = '0;
    go_pd = 1'b0;
    go_idle = 1'b0;
    n.ctx = 1'b0;
    n.start = 1'b0;
    wm = s.wd & {{8{s.ws[3]}}, {8{s.ws[2]}}, {8{s.ws[1]}}, {8{s.ws[0]}}};
    wen = s.awh && s.wh && !s.bv;

    // processor cycle enable; only slowed idle stretches it
    case (s.idiv)
      3'h1:    lim = 7'h0f;
      3'h2:    lim = 7'h1f;
      3'h3:    lim = 7'h3f;
      default: lim = 7'h7f;
    endcase
    if (s.st == ST_IDLE && s.idiv != 3'h0 && s.idiv <= 3'h4) begin
      n.cyc = (s.div == 7'h00);
      n.div = (s.div == 7'h00) ? lim : s.div - 7'h01;
    end else begin
      n.cyc = 1'b1;
      n.div = 7'h00;
    end
    // cycle clock output frozen while disabled to save pin power
    if (s.cyc && !s.clk_dis) begin
      n.clko = ~s.clko;
    end
    if (s.blk && s.cyc) begin
      n.blk = 1'b0;
    end

    // edge events: power-down and edge pin always, ext pins by control bits
    set[SRC_PD] = fall[4];
    set[SRC_IE] = fall[3];
    set[SRC_I2] = fall[2] && s.interrupt_control_reg[2];
    set[SRC_S1T] = (fall[1] && s.interrupt_control_reg[1]) || periph_irq_i[3];
    set[SRC_S1R] = (fall[0] && s.interrupt_control_reg[0]) || periph_irq_i[4];
    set[SRC_S0T] = periph_irq_i[0];
    set[SRC_S0R] = periph_irq_i[1];
    set[SRC_BD] = periph_irq_i[2];
    set[SRC_TMR] = periph_irq_i[5];
    lvl[SRC_LA] = !level_interrupt_in_a_n_i;
    lvl[SRC_LB] = !level_interrupt_in_b_n_i;
    lvl[SRC_I2] = !ext_interrupt_two_n_i && !s.interrupt_control_reg[2];
    lvl[SRC_S1T] = !ext_interrupt_one_n_i && !s.interrupt_control_reg[1];
    lvl[SRC_S1R] = !ext_interrupt_zero_n_i && !s.interrupt_control_reg[0];

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    if (awvalid_i && s.awr) begin
      n.awh = 1'b1;
      n.awa = awaddr_i[7:0];
    end
    if (wvalid_i && s.wr) begin
      n.wh = 1'b1;
      n.wd = wdata_i;
      n.ws = wstrb_i;
    end
    if (s.bv && bready_i) begin
      n.bv = 1'b0;
    end
    if (wen) begin
      n.awh = 1'b0;
      n.wh = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OKAY;
      if (s.awa == MASK_OFS) begin
        n.mask = wm[9:0];
        n.blk = 1'b1;
      end else if (s.awa == INTERRUPT_CONTROL_REG_OFS) begin
        n.interrupt_control_reg = wm[3:0];
      end else if (s.awa == IFC_OFS) begin
        set = set | wm[SRC_N-1:0];
        clr = wm[IFC_CLR_POS +: SRC_N];
      end else if (s.awa == GIE_OFS) begin
        n.gie = wm[0];
      end else if (s.awa == PWR_OFS) begin
        set[SRC_PD] = set[SRC_PD] | wm[PWR_FORCE];
        n.osc_off = wm[PWR_OSC_OFF];
        n.ctx_clr = wm[PWR_CTX_CLR];
        n.clk_dis = wm[PWR_CLK_DIS];
        n.idiv = wm[PWR_DIV_POS +: 3];
        go_pd = wm[PWR_ENTER];
        go_idle = wm[PWR_IDLE];
      end else if (s.awa == MODE_STATUS_REG_OFS) begin
        n.mode_status_reg = wm[6:0];
      end else begin
        n.br = RESP_SLV;
      end
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    eff = s.pend | lvl;
    top_i = 4'(SRC_N);
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (s.isr[i]) top_i = 4'(i);
    end
    cand = eff & {s.mask, 1'b1};
    for (int i = 0; i < SRC_N; i++) begin
      if (s.interrupt_control_reg[INTERRUPT_CONTROL_REG_NEST] ? (4'(i) >= top_i) : (s.isr != '0)) cand[i] = 1'b0;
    end
    pick = 4'h0;
    found = 1'b0;
    for (int i = 0; i < SRC_N; i++) begin
      if (cand[i] && !found) begin
        pick = 4'(i);
        found = 1'b1;
      end
    end
    allow = s.gie && !s.blk && (s.st == ST_RUN || s.st == ST_IDLE);
    take = core_i.int_ack && s.irq;
    if (take) begin
      clr[s.vec] = 1'b1;
      n.isr[s.vec] = 1'b1;
    end
    if (core_i.rti && top_i < 4'(SRC_N)) begin
      n.isr[top_i] = 1'b0;
    end
    n.pend = (s.pend & ~clr) | set; // set beats clear
    n.irq = allow && found && !take;
    n.vec = pick;
    n.vaddr = VEC_ADDR[pick];

    // shared status stack
    push = take || core_i.loop_push;
    pop = core_i.rti || core_i.loop_pop;
    if (push && !pop && s.sp < STK_DEPTH) begin
      n.stk[s.sp] = core_i.status;
      n.sp = s.sp + 4'h1;
    end else if (pop && !push && s.sp != 4'h0) begin
      n.top = s.stk[s.sp - 4'h1];
      n.sp = s.sp - 4'h1;
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    case (s.st)
      ST_BOOT: begin
        if (!bus_req_i && (!boot_cfg_i || boot_done_i)) begin
          n.st = ST_RUN;
          n.start = 1'b1;
        end
      end
      ST_RUN: begin
        if (go_pd) begin
          n.st = ST_PD;
        end else if (go_idle) begin
          n.st = ST_IDLE;
          n.div = lim;
        end
      end
      ST_IDLE: begin
        // wake only on a cycle edge, so slowed idle lingers up to n cycles
        if (found && s.gie && s.cyc) begin
          n.st = ST_RUN;
        end
      end
      ST_PD: begin
        if (power_down_pin_n_i) begin
          n.st = ST_WAKE;
          n.cnt = s.osc_off ? WAKE_CRYSTAL_PIN_CYC : WAKE_FAST_CYC;
        end
      end
      ST_WAKE: begin
        n.cnt = s.cnt - 13'h0001;
        if (s.cnt == 13'h0000) begin
          n.st = ST_RUN;
          if (s.ctx_clr) begin
            n.ctx = 1'b1;
            n.isr = '0;
            n.sp = 4'h0;
          end
        end
      end
      default: n.st = ST_BOOT;
    endcase
    n.pd_ack = (n.st == ST_PD);

    if (arvalid_i && s.arr) begin
      if (araddr_i[7:0] == MASK_OFS) begin
        rdv[9:0] = s.mask;
      end else if (araddr_i[7:0] == INTERRUPT_CONTROL_REG_OFS) begin
        rdv[3:0] = s.interrupt_control_reg;
      end else if (araddr_i[7:0] == IFC_OFS) begin
        rdv = '0;
      end else if (araddr_i[7:0] == GIE_OFS) begin
        rdv[0] = s.gie;
      end else if (araddr_i[7:0] == PEND_OFS) begin
        rdv[SRC_N-1:0] = eff;
      end else if (araddr_i[7:0] == PWR_OFS) begin
        rdv[PWR_OSC_OFF] = s.osc_off;
        rdv[PWR_CTX_CLR] = s.ctx_clr;
        rdv[PWR_CLK_DIS] = s.clk_dis;
        rdv[PWR_DIV_POS +: 3] = s.idiv;
      end else if (araddr_i[7:0] == STAT_OFS) begin
        rdv[2:0] = s.st;
        rdv[3] = s.pd_ack;
        rdv[7:4] = s.sp;
        rdv[STAT_ISR_POS +: SRC_N] = s.isr;
      end else if (araddr_i[7:0] == MODE_STATUS_REG_OFS) begin
        rdv[6:0] = s.mode_status_reg;
      end
      n.rv = 1'b1;
      n.rd = rdv;
      n.rr = (araddr_i[7:0] <= MODE_STATUS_REG_OFS && araddr_i[1:0] == 2'h0) ? RESP_OKAY : RESP_SLV;
    end else if (s.rv && rready_i) begin
      n.rv = 1'b0;
    end
    n.awr = !n.awh && !n.bv;
    n.wr = !n.wh && !n.bv;
    n.arr = !n.rv;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s <= '0;
      s.gie <= GIE_RST;
      s.prev <= 5'h1f;
    end else begin
      s <= n;
    end
  end

  assign awready_o = s.awr;
  assign wready_o = s.wr;
  assign bvalid_o = s.bv;
  assign bresp_o = s.br;
  assign arready_o = s.arr;
  assign rvalid_o = s.rv;
  assign rdata_o = s.rd;
  assign rresp_o = s.rr;
  assign irq_o = s.irq;
  assign irq_src_o = s.vec;
  assign vector_addr_o = s.vaddr;
  assign stack_top_o = s.top;
  assign stall_o = (s.st != ST_RUN);
  assign cyc_en_o = s.cyc;
  assign cycle_clock_output_o = s.clko;
  assign power_down_ack_o = s.pd_ack;
  assign ctx_clear_o = s.ctx;
  assign start_o = s.start;
  assign start_pc_o = START_PC;
  assign mode_status_reg_o = s.mode_status_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  mask_block_a: assert property (s.blk |=> !$rose(s.irq))
    else $error("interrupt raised during mask block");
  global_gate_a: assert property (!s.gie |=> !$rose(s.irq))
    else $error("interrupt raised while globally disabled");
  pd_nomask_a: assert property ((s.st == ST_RUN) && s.pend[SRC_PD] && s.gie && !s.blk
    && (s.isr == '0) && !(core_i.int_ack && s.irq) |=> s.irq && (s.vec == 4'h0))
    else $error("power-down request not raised");
  reset_state_a: assert property ($rose(nrst_i) |-> s.gie && (s.mask == '0)
    && (s.sp == 4'h0) && (s.mode_status_reg == '0))
    else $error("bad state after reset");
  wake_load_a: assert property ($rose(s.st == ST_WAKE) |-> s.cnt == ($past(s.osc_off)
    ? WAKE_CRYSTAL_PIN_CYC : WAKE_FAST_CYC))
    else $error("wake count wrong");
  stack_depth_a: assert property (s.sp <= STK_DEPTH)
    else $error("stack beyond twelve entries");
  pd_ack_a: assert property ((s.st == ST_PD) && power_down_pin_n_i |=> !power_down_ack_o)
    else $error("power-down acknowledge held after pin release");
  idle_exit_a: assert property ((s.st == ST_IDLE) && (s.pend[SRC_PD] || s.pend[SRC_IE]
    && s.mask[SRC_IE-1]) && s.gie && (s.isr == '0) |-> ##[1:130] (s.st != ST_IDLE))
    else $error("idle exit took too long");
  clk_off_a: assert property (s.clk_dis && $past(s.clk_dis) |=> $stable(cycle_clock_output_o))
    else $error("clock output toggled while disabled");
endmodule

// ### pkg/dip_pkg.sv
// constants and types shared by the interrupt and power control block
package dip_pkg;
  // register byte offsets
  localparam logic [7:0] MASK_OFS  = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_OFS = 8'h04;
  localparam logic [7:0] IFC_OFS   = 8'h08;
  localparam logic [7:0] GIE_OFS   = 8'h0c;
  localparam logic [7:0] PEND_OFS  = 8'h10;
  localparam logic [7:0] PWR_OFS   = 8'h14;
  localparam logic [7:0] STAT_OFS  = 8'h18;
  localparam logic [7:0] MODE_STATUS_REG_OFS = 8'h1c;
  // field positions
  localparam int IFC_CLR_POS  = 16;
  localparam int PWR_FORCE    = 0;
  localparam int PWR_OSC_OFF  = 1;
  localparam int PWR_CTX_CLR  = 2;
  localparam int PWR_ENTER    = 3;
  localparam int PWR_CLK_DIS  = 4;
  localparam int PWR_DIV_POS  = 8;
  localparam int PWR_IDLE     = 11;
  localparam int INTERRUPT_CONTROL_REG_NEST   = 3;
  localparam int STAT_ISR_POS = 16;
  // source indices, lower index wins
  localparam int SRC_N   = 11;
  localparam int SRC_PD  = 0;
  localparam int SRC_I2  = 1;
  localparam int SRC_LB  = 2;
  localparam int SRC_LA  = 3;
  localparam int SRC_S0T = 4;
  localparam int SRC_S0R = 5;
  localparam int SRC_IE  = 6;
  localparam int SRC_BD  = 7;
  localparam int SRC_S1T = 8;
  localparam int SRC_S1R = 9;
  localparam int SRC_TMR = 10;
  localparam logic [SRC_N-1:0][13:0] VEC_ADDR = {14'h0028, 14'h0024, 14'h0020,
    14'h001c, 14'h0018, 14'h0014, 14'h0010, 14'h000c, 14'h0008, 14'h0004, 14'h002c};
  // reset values and counts
  localparam logic       GIE_RST    = 1'b1;
  localparam logic [3:0] STK_DEPTH  = 4'hc;
  localparam int         WAKE_FAST  = 400;
  localparam int         WAKE_CRYSTAL_PIN  = 4096;
  localparam logic [15:0] START_PC  = 16'h0000;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_RUN  = 3'h1,
    ST_IDLE = 3'h3,
    ST_PD   = 3'h2,
    ST_WAKE = 3'h6
  } dip_state_e;

  typedef struct packed {
    logic        int_ack;
    logic        rti;
    logic        loop_push;
    logic        loop_pop;
    logic [15:0] status;
  } dip_core_s;
endpackage

// ### testbench/dip_far_model.sv
// far-side model: interrupt and power-down pins plus the core answering requests
`timescale 1ns/1ps
module dip_far_model
  import dip_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic [6:0] req_i,
  input  wire logic       push_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       irq_i,
  input  wire logic       stall_i,
  output logic [6:0]      pins_n_o,
  output dip_core_s       core_o
);
  typedef struct packed {
    logic [6:0] pins_n;
    logic [3:0] wait_cnt;
    logic [3:0] rti_cnt;
    logic       ack;
    logic       rti;
  } dip_far_s;
  dip_far_s st_ff;
  dip_far_s nxt_st;

  // --------------------------------------------
  // pins idle high; core acks after dly_i cycles
  // --------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pins_n = ~req_i;
    nxt_st.ack = 1'b0;
    nxt_st.rti = 1'b0;
    // a stalled core cannot take a request, so acks wait for the run state
    if (irq_i && !stall_i && !st_ff.ack) begin
      nxt_st.wait_cnt = st_ff.wait_cnt + 4'h1;
      if (st_ff.wait_cnt >= dly_i) begin
        nxt_st.ack = 1'b1;
        nxt_st.wait_cnt = 4'h0;
        nxt_st.rti_cnt = 4'h8;
      end
    end
    // one return per ack, so nested service is never claimed
    if (st_ff.rti_cnt != 4'h0) begin
      nxt_st.rti_cnt = st_ff.rti_cnt - 4'h1;
      nxt_st.rti = (st_ff.rti_cnt == 4'h1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_ff <= '{pins_n: 7'h7f, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins_n_o = st_ff.pins_n;
  assign core_o = '{int_ack: st_ff.ack, rti: st_ff.rti, loop_push: push_i, loop_pop: 1'b0,
                    status: 16'hc35a};
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the interrupt and power control block
`timescale 1ns/1ps
module tb_top
  import dip_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, stall, cyc_en, ck_out;
  logic        pd_ack, ctx_clr, start;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  irq_src;
  logic [13:0] vec;
  logic [15:0] stk_top, start_pc;
  logic [6:0]  mode_status_reg, pins_n;
  logic [6:0]  req = 7'h00;
  logic        push = 1'b0, bus_req = 1'b0;
  dip_core_s   core;
  int          n_mismatch = 0;
  int          check_count = 0;

  dip_ctrl i_dip_ctrl (
    .clk_sys_i(clk), .nrst_i(nrst), .awaddr_i(awaddr), .awvalid_i(awvalid),
    .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
    .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
    .power_down_pin_n_i(pins_n[0]), .edge_interrupt_in_n_i(pins_n[1]),
    .level_interrupt_in_a_n_i(pins_n[2]), .level_interrupt_in_b_n_i(pins_n[3]),
    .ext_interrupt_zero_n_i(pins_n[4]), .ext_interrupt_one_n_i(pins_n[5]),
    .ext_interrupt_two_n_i(pins_n[6]), .periph_irq_i(6'h00), .core_i(core),
    .bus_req_i(bus_req), .boot_cfg_i(1'b0), .boot_done_i(1'b0), .irq_o(irq),
    .irq_src_o(irq_src), .vector_addr_o(vec), .stack_top_o(stk_top), .stall_o(stall),
    .cyc_en_o(cyc_en), .cycle_clock_output_o(ck_out), .power_down_ack_o(pd_ack),
    .ctx_clear_o(ctx_clr), .start_o(start), .start_pc_o(start_pc), .mode_status_reg_o(mode_status_reg)
  );

  dip_far_model i_dip_far_model (
    .clk_sys_i(clk), .nrst_i(nrst), .req_i(req), .push_i(push), .dly_i(4'h3),
    .irq_i(irq), .stall_i(stall), .pins_n_o(pins_n), .core_o(core)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ------------------
  // bus and check tasks
  // ------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic lost(input string nm);
    $display("BAD %s expected done seen timeout", nm);
    n_mismatch++;
    test_done();
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic wt(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v) begin
      @(posedge clk);
      n++;
      if (n > lim) lost("wait");
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (++n > 200) lost("write");
    end while (bvalid !== 1'b1);
    chk($sformatf("bresp %h", a), 32'(er), 32'(bresp));
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (++n > 200) lost("read");
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk($sformatf("reg %h", a), e, d & m);
  endtask

  task automatic rst(input int c);
    int n;
    nrst <= 1'b0;
    bus_req <= 1'b1;
    repeat (c) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("boot held", 32'h1, 32'(stall));
    bus_req <= 1'b0;
    wt(start, 1'b1, 50, n);
    chk("start", 32'h1, 32'(start));
  endtask

  task automatic pulse(input logic [6:0] v);
    req <= v;
    repeat (3) @(posedge clk);
    req <= 7'h00;
    repeat (4) @(posedge clk);
  endtask

  // wake takes longest of all waits, so the ctx pulse is caught along the way
  task automatic wake(output int n, output logic seen);
    n = 0;
    seen = 1'b0;
    while (stall !== 1'b0) begin
      @(posedge clk);
      n++;
      if (ctx_clr === 1'b1) seen = 1'b1;
      if (n > 5000) lost("wake");
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    lost("run");
  end

  // ---------
  // scenarios
  // ---------
  initial begin
    int          n;
    int          div;
    logic        seen;
    logic        p;
    logic [31:0] d;
    logic [1:0]  r;
    rst(20); // synchronous reset, no lock time to wait out
    rc(GIE_OFS, 32'h1, 32'h1);
    rc(MASK_OFS, 32'h3ff, 32'h0);
    rc(MODE_STATUS_REG_OFS, 32'h7f, 32'h0);
    chk("start pc", 32'h0, 32'(start_pc));
    push <= 1'b1;
    repeat (13) @(posedge clk);
    push <= 1'b0;
    rc(STAT_OFS, 32'hf0, 32'(STK_DEPTH) << 4);
    wr(MODE_STATUS_REG_OFS, 32'h7f, RESP_OKAY);
    chk("mode_status_reg out", 32'h7f, 32'(mode_status_reg));
    rst(3);
    rc(STAT_OFS, 32'hf0, 32'h0);
    rc(MODE_STATUS_REG_OFS, 32'h7f, 32'h0);
    wr(8'h20, 32'h1, RESP_SLV);
    rd(8'h22, d, r);
    chk("rresp", 32'(RESP_SLV), 32'(r));
    rc(IFC_OFS, 32'hffffffff, 32'h0);
    $display("test reset and bus done");
    for (int i = 0; i < 2; i++) begin
      wr(MASK_OFS, (i == 0) ? 32'h4 : 32'h6, RESP_OKAY);
      req <= 7'h0c;
      wt(irq, 1'b1, 50, n);
      chk("src", (i == 0) ? SRC_LA : SRC_LB, 32'(irq_src));
      chk("vector", 32'(VEC_ADDR[(i == 0) ? SRC_LA : SRC_LB]), 32'(vec));
      wt(irq, 1'b0, 50, n);
      req <= 7'h00;
      repeat (20) @(posedge clk);
      chk("stack top", 32'h0000c35a, 32'(stk_top));
    end
    $display("test priority done");
    wr(GIE_OFS, 32'h0, RESP_OKAY);
    wr(MASK_OFS, 32'h20, RESP_OKAY);
    wr(IFC_OFS, 32'h40, RESP_OKAY);
    rc(PEND_OFS, 32'h40, 32'h40);
    chk("irq", 32'h0, 32'(irq));
    wr(IFC_OFS, 32'h00400000, RESP_OKAY);
    rc(PEND_OFS, 32'h40, 32'h0);
    pulse(7'h02);
    rc(PEND_OFS, 32'h40, 32'h40);
    wr(INTERRUPT_CONTROL_REG_OFS, 32'h4, RESP_OKAY);
    pulse(7'h40);
    rc(PEND_OFS, 32'h2, 32'h2);
    wr(IFC_OFS, 32'h00420000, RESP_OKAY);
    wr(INTERRUPT_CONTROL_REG_OFS, 32'h0, RESP_OKAY);
    pulse(7'h40);
    rc(PEND_OFS, 32'h42, 32'h0);
    wr(GIE_OFS, 32'h1, RESP_OKAY);
    $display("test force clear done");
    wr(MASK_OFS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      req <= 7'h01;
      wt(irq, 1'b1, 50, n);
      chk("pd src", SRC_PD, 32'(irq_src));
      chk("pd vector", 32'(VEC_ADDR[SRC_PD]), 32'(vec));
      wr(PWR_OFS, (i == 0) ? 32'h8 : 32'he, RESP_OKAY);
      wt(pd_ack, 1'b1, 10, n);
      chk("pd ack", 32'h1, 32'(pd_ack));
      req <= 7'h00;
      wake(n, seen);
      div = (i == 0) ? WAKE_FAST : WAKE_CRYSTAL_PIN;
      chk("wake time", 32'h1, 32'(n >= div && n <= div + 6));
      chk("ctx clear", 32'(i), 32'(seen));
      repeat (20) @(posedge clk);
    end
    wr(PWR_OFS, 32'h1, RESP_OKAY);
    wt(irq, 1'b1, 50, n);
    chk("force src", SRC_PD, 32'(irq_src));
    repeat (20) @(posedge clk);
    req <= 7'h01;
    wt(irq, 1'b1, 50, n);
    wr(PWR_OFS, 32'h8, RESP_OKAY);
    wt(pd_ack, 1'b1, 10, n);
    req <= 7'h00;
    rst(2);
    chk("pd ack after reset", 32'h0, 32'(pd_ack));
    $display("test power down done");
    wr(MASK_OFS, 32'h20, RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      div = (k == 0) ? 1 : 16 << (k - 1);
      wr(PWR_OFS, 32'h800 | (32'(k) << 8), RESP_OKAY);
      if (k > 0) begin
        wt(cyc_en, 1'b1, 300, n);
        @(posedge clk);
        wt(cyc_en, 1'b1, 300, n);
        chk("cycle gap", 32'(div), 32'(n + 1));
      end
      chk("stalled", 32'h1, 32'(stall));
      wr(IFC_OFS, 32'h40, RESP_OKAY);
      wt(stall, 1'b0, div + 20, n);
      chk("idle exit", 32'h1, 32'(n <= div + 4));
      repeat (20) @(posedge clk);
    end
    $display("test idle done");
    for (int i = 0; i < 2; i++) begin
      wr(PWR_OFS, (i == 0) ? 32'h10 : 32'h0, RESP_OKAY);
      n = 0;
      p = ck_out;
      repeat (8) begin
        @(posedge clk);
        if (ck_out !== p) n++;
        p = ck_out;
      end
      chk("clock out toggles", 32'(i), 32'(n >= 3));
    end
    $display("test clock out done");
    test_done();
  end
endmodule
